/* logic/rdst_top.sv */
// daylight-saving scheduler and power-switchover time stamps of the real time clock
`timescale 1ns/1ns
`default_nettype none
`include "rdst_params.svh"
module rdst_top
  import rdst_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] rtc_sec,
  input  wire logic [7:0] rtc_min,
  input  wire logic [7:0] rtc_hour,
  input  wire logic [7:0] rtc_date,
  input  wire logic [7:0] rtc_month,
  input  wire logic [2:0] rtc_dow,
  input  wire logic       rtc_leap_year,
  input  wire logic       rtc_tick,
  input  wire logic       to_battery,
  input  wire logic       to_main,
  output logic            hour_step_fwd,
  output logic            hour_step_back,
  output logic            dst_applied_flag
);

  rdst_state_t s;
  rdst_state_t next_s;

  function automatic logic [4:0] bcd_to_bin(input logic [5:0] bcd);
    logic [4:0] tens;
    tens = {3'h0, bcd[5:4]};
    return 5'((tens << 3) + (tens << 1) + {1'b0, bcd[3:0]});
  endfunction

  logic [4:0] date_bin;
  logic [4:0] month_days;
  logic [2:0] week_now;
  logic       last_week;
  logic       top_of_hour;

  always_comb begin
    date_bin = bcd_to_bin(rtc_date[5:0]);
    if (rtc_month[4:0] == `RDST_BCD_FEB) begin
      month_days = rtc_leap_year ? 5'd29 : 5'd28;
    end else if (rtc_month[4:0] == `RDST_BCD_APR || rtc_month[4:0] == `RDST_BCD_JUN ||
                 rtc_month[4:0] == `RDST_BCD_SEP || rtc_month[4:0] == `RDST_BCD_NOV) begin
      month_days = 5'd30;
    end else begin
      month_days = 5'd31;
    end
    week_now    = 3'((date_bin - 5'd1) / 5'd7 + 5'd1);
    last_week   = ({1'b0, date_bin} + 6'd7) > {1'b0, month_days};
    top_of_hour = (rtc_sec == 8'h00) && (rtc_min == 8'h00);
  end

  function automatic logic sched_match(input rdst_sched_t sc);
    logic day_ok;
    logic week_ok;
    week_ok = (sc.weekday[5:3] == `RDST_WEEK_LAST) ? last_week : (sc.weekday[5:3] == week_now);
    if (sc.weekday[`RDST_BIT_WEEK_SELECT]) begin
      day_ok = week_ok && (sc.weekday[2:0] == rtc_dow);
    end else begin
      day_ok = (sc.date[5:0] == rtc_date[5:0]);
    end
    // hour compared in the clock's own encoding, so 12h and 24h both work
    return day_ok && (sc.month[4:0] == rtc_month[4:0]) && (sc.hour[5:0] == rtc_hour[5:0]);
  endfunction

  logic fwd_hit;
  logic rev_hit;
  logic enabled;

  always_comb begin
    enabled = s.fwd.month[`RDST_BIT_ENABLE];
    // needs the clock to pass the scheduled hour after enabling
    fwd_hit = rtc_tick && top_of_hour && enabled && !s.dst_applied_flag && sched_match(s.fwd);
    rev_hit = rtc_tick && top_of_hour && enabled && s.dst_applied_flag && sched_match(s.rev);
  end

  logic [7:0] rd_mux;
  logic [7:0] m2b_ofs;
  logic [7:0] b2m_ofs;
  logic [2:0] m2b_idx;
  logic [2:0] b2m_idx;

  always_comb begin
    // offsets kept at full width so higher addresses do not alias onto a stamp
    m2b_ofs = reg_addr - `RDST_OFS_STAMP_M2B;
    b2m_ofs = reg_addr - `RDST_OFS_STAMP_B2M;
    m2b_idx = m2b_ofs[2:0];
    b2m_idx = b2m_ofs[2:0];
    rd_mux  = 8'h00;
    unique case (1'b1)
      reg_addr == `RDST_OFS_STATUS:      rd_mux = {7'h00, s.dst_applied_flag};
      reg_addr == `RDST_OFS_PWR_CTRL:    rd_mux = 8'h00;
      reg_addr == `RDST_OFS_MONTH_FWD:   rd_mux = s.fwd.month;
      reg_addr == `RDST_OFS_WEEKDAY_FWD: rd_mux = s.fwd.weekday;
      reg_addr == `RDST_OFS_DATE_FWD:    rd_mux = s.fwd.date;
      reg_addr == `RDST_OFS_HOUR_FWD:    rd_mux = s.fwd.hour;
      reg_addr == `RDST_OFS_MONTH_REV:   rd_mux = s.rev.month;
      reg_addr == `RDST_OFS_WEEKDAY_REV: rd_mux = s.rev.weekday;
      reg_addr == `RDST_OFS_DATE_REV:    rd_mux = s.rev.date;
      reg_addr == `RDST_OFS_HOUR_REV:    rd_mux = s.rev.hour;
      (reg_addr >= `RDST_OFS_STAMP_M2B) && (m2b_ofs < 8'(`RDST_STAMP_BYTES)):
        rd_mux = s.stamp_main_to_battery[m2b_idx];
      (reg_addr >= `RDST_OFS_STAMP_B2M) && (b2m_ofs < 8'(`RDST_STAMP_BYTES)):
        rd_mux = s.stamp_battery_to_main[b2m_idx];
      default:                           rd_mux = 8'h00;
    endcase
  end

  rdst_stamp_t now_stamp;
  logic        clear_req;

  always_comb begin
    now_stamp = {rtc_month, rtc_date, rtc_hour, rtc_min, rtc_sec};
    clear_req = reg_wr && (reg_addr == `RDST_OFS_PWR_CTRL) && reg_wdata[`RDST_BIT_CLEAR_STAMPS];
  end

  always_comb begin
    next_s = s;
    next_s.hour_step_fwd  = 1'b0;
    next_s.hour_step_back = 1'b0;
    next_s.rdata          = reg_rd ? rd_mux : 8'h00;

    if (reg_wr) begin
      unique case (reg_addr)
        `RDST_OFS_MONTH_FWD: begin
          next_s.fwd.month = reg_wdata & `RDST_MASK_MONTH_FWD;
          if (!reg_wdata[`RDST_BIT_ENABLE]) begin
            next_s.dst_applied_flag = 1'b0;
          end
        end
        `RDST_OFS_WEEKDAY_FWD: next_s.fwd.weekday = reg_wdata & `RDST_MASK_WEEKDAY;
        `RDST_OFS_DATE_FWD:    next_s.fwd.date    = reg_wdata & `RDST_MASK_DATE;
        `RDST_OFS_HOUR_FWD:    next_s.fwd.hour    = reg_wdata & `RDST_MASK_HOUR;
        `RDST_OFS_MONTH_REV:   next_s.rev.month   = reg_wdata & `RDST_MASK_MONTH_REV;
        `RDST_OFS_WEEKDAY_REV: next_s.rev.weekday = reg_wdata & `RDST_MASK_WEEKDAY;
        `RDST_OFS_DATE_REV:    next_s.rev.date    = reg_wdata & `RDST_MASK_DATE;
        `RDST_OFS_HOUR_REV:    next_s.rev.hour    = reg_wdata & `RDST_MASK_HOUR;
        default: begin
        end
      endcase
    end

    if (clear_req) begin
      next_s.stamp_main_to_battery = '0;
      next_s.stamp_battery_to_main = '0;
      next_s.m2b_taken             = 1'b0;
    end

    // a switch to main in the clearing cycle is still captured, a switch to battery only if m2b_taken was already clear
    if (to_battery && !s.m2b_taken) begin
      next_s.stamp_main_to_battery = now_stamp;
      next_s.m2b_taken             = 1'b1;
    end
    if (to_main) begin
      next_s.stamp_battery_to_main = now_stamp;
    end

    if (fwd_hit) begin
      next_s.hour_step_fwd    = 1'b1;
      next_s.dst_applied_flag = 1'b1;
    end
    if (rev_hit) begin
      next_s.hour_step_back   = 1'b1;
      next_s.dst_applied_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.fwd.month             <= `RDST_RST_MONTH_FWD;
      s.fwd.weekday           <= `RDST_RST_FIELD;
      s.fwd.date              <= `RDST_RST_FIELD;
      s.fwd.hour              <= `RDST_RST_FIELD;
      s.rev.month             <= `RDST_RST_MONTH_REV;
      s.rev.weekday           <= `RDST_RST_FIELD;
      s.rev.date              <= `RDST_RST_FIELD;
      s.rev.hour              <= `RDST_RST_FIELD;
      s.stamp_main_to_battery <= '0;
      s.stamp_battery_to_main <= '0;
      s.m2b_taken             <= 1'b0;
      s.dst_applied_flag      <= 1'b0;
      s.hour_step_fwd         <= 1'b0;
      s.hour_step_back        <= 1'b0;
      s.rdata                 <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata        = s.rdata;
  assign hour_step_fwd    = s.hour_step_fwd;
  assign hour_step_back   = s.hour_step_back;
  assign dst_applied_flag = s.dst_applied_flag;

endmodule : rdst_top
`default_nettype wire

/* logic/rdst_params.svh */
// register offsets, field positions and reset values of the daylight-saving and time-stamp block
`ifndef RDST_PARAMS_SVH
`define RDST_PARAMS_SVH
`define RDST_OFS_STATUS        8'h07
`define RDST_OFS_PWR_CTRL      8'h09
`define RDST_OFS_MONTH_FWD     8'h15
`define RDST_OFS_WEEKDAY_FWD   8'h16
`define RDST_OFS_DATE_FWD      8'h17
`define RDST_OFS_HOUR_FWD      8'h18
`define RDST_OFS_MONTH_REV     8'h19
`define RDST_OFS_WEEKDAY_REV   8'h1A
`define RDST_OFS_DATE_REV      8'h1B
`define RDST_OFS_HOUR_REV      8'h1C
`define RDST_OFS_STAMP_M2B     8'h30
`define RDST_OFS_STAMP_B2M     8'h35
`define RDST_STAMP_BYTES       3'h5
`define RDST_BIT_APPLIED       0
`define RDST_BIT_CLEAR_STAMPS  0
`define RDST_BIT_ENABLE        7
`define RDST_BIT_WEEK_SELECT   6
`define RDST_MASK_MONTH_FWD    8'h9F
`define RDST_MASK_MONTH_REV    8'h1F
`define RDST_MASK_WEEKDAY      8'h7F
`define RDST_MASK_DATE         8'h3F
`define RDST_MASK_HOUR         8'h3F
`define RDST_RST_MONTH_FWD     8'h00
`define RDST_RST_MONTH_REV     8'h10
`define RDST_RST_FIELD         8'h00
`define RDST_WEEK_LAST         3'h7
`define RDST_BCD_FEB           5'h02
`define RDST_BCD_APR           5'h04
`define RDST_BCD_JUN           5'h06
`define RDST_BCD_SEP           5'h09
`define RDST_BCD_NOV           5'h11
`endif

/* logic/rdst_pkg.sv */
// types of the daylight-saving and time-stamp block
`default_nettype none
package rdst_pkg;
  typedef logic [7:0]      rdst_byte_t;
  typedef rdst_byte_t [4:0] rdst_stamp_t;
  typedef struct packed {
    rdst_byte_t  month;
    rdst_byte_t  weekday;
    rdst_byte_t  date;
    rdst_byte_t  hour;
  } rdst_sched_t;
  typedef struct packed {
    rdst_sched_t fwd;
    rdst_sched_t rev;
    rdst_stamp_t stamp_main_to_battery;
    rdst_stamp_t stamp_battery_to_main;
    logic        m2b_taken;
    logic        dst_applied_flag;
    logic        hour_step_fwd;
    logic        hour_step_back;
    rdst_byte_t  rdata;
  } rdst_state_t;
endpackage : rdst_pkg
`default_nettype wire

/* verif/rdst_top_asserts.sv */
// port assertions of the daylight-saving and time-stamp block
`timescale 1ns/1ns
`default_nettype none
module rdst_top_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] rtc_sec,
  input wire logic [7:0] rtc_min,
  input wire logic       rtc_tick,
  input wire logic       to_battery,
  input wire logic       hour_step_fwd,
  input wire logic       hour_step_back,
  input wire logic       dst_applied_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic top_tick;
  logic dis_wr;
  assign top_tick = rtc_tick && rtc_sec == 8'h00 && rtc_min == 8'h00;
  assign dis_wr   = reg_wr && reg_addr == 8'h15 && !reg_wdata[7];
  property p_fwd_cause;
    hour_step_fwd |-> $past(top_tick && !dst_applied_flag) && dst_applied_flag;
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("forward step without cause");
  property p_fwd_once;
    hour_step_fwd |=> !hour_step_fwd;
  endproperty
  a_fwd_once: assert property (p_fwd_once) else $error("forward step longer than one cycle");
  property p_back_cause;
    hour_step_back |-> $past(top_tick && dst_applied_flag) && !dst_applied_flag;
  endproperty
  a_back_cause: assert property (p_back_cause) else $error("reverse step without cause");
  property p_rise;
    $rose(dst_applied_flag) |-> hour_step_fwd;
  endproperty
  a_rise: assert property (p_rise) else $error("applied flag rose without forward step");
  property p_fall;
    $fell(dst_applied_flag) |-> hour_step_back || $past(dis_wr);
  endproperty
  a_fall: assert property (p_fall) else $error("applied flag fell without cause");
  property p_disable;
    dis_wr && !rtc_tick |=> !dst_applied_flag;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not clear applied flag");
  property p_status;
    reg_rd && reg_addr == 8'h07 |=> reg_rdata == {7'h00, $past(dst_applied_flag)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  property p_clear;
    reg_wr && reg_addr == 8'h09 && reg_wdata[0] && !to_battery ##1 !to_battery ##1 reg_rd && reg_addr == 8'h30
      |=> reg_rdata == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("stamp not zero after clear");
  property p_excl;
    !(hour_step_fwd && hour_step_back);
  endproperty
  a_excl: assert property (p_excl) else $error("both steps at once");
  c_fwd: cover property (hour_step_fwd);
  c_back: cover property (hour_step_back);
  c_dis: cover property (dis_wr && dst_applied_flag);
endmodule // rdst_top_chk
bind rdst_top rdst_top_chk i_rdst_top_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rtc_sec, .rtc_min, .rtc_tick, .to_battery, .hour_step_fwd, .hour_step_back, .dst_applied_flag);
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench of the daylight-saving and time-stamp block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] sec = 8'h00, min = 8'h00, hour = 8'h00, date = 8'h00, month = 8'h00;
  logic [2:0] dow = 3'h0;
  logic       tick = 1'b0, to_battery = 1'b0, to_main = 1'b0, step_f, step_b, flag;
  int         error_cnt = 0, checks_done = 0;
  always #50 clk = ~clk;
  rdst_top i_rdst_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rtc_sec(sec),
    .rtc_min(min), .rtc_hour(hour), .rtc_date(date), .rtc_month(month), .rtc_dow(dow), .rtc_leap_year(1'b0),
    .rtc_tick(tick), .to_battery, .to_main, .hour_step_fwd(step_f), .hour_step_back(step_b),
    .dst_applied_flag(flag));
  task automatic chk(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask
  task automatic at(input logic [7:0] h, d, mo, input logic [2:0] w);
    @(posedge clk);
    hour <= h;
    date <= d;
    month <= mo;
    dow <= w;
  endtask
  // one tick at the top of the hour, then the step pulse and flag are judged
  task automatic fire(input logic f, b, fl);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(negedge clk);
    chk("hour_step_fwd", {7'h00, f}, {7'h00, step_f});
    chk("hour_step_back", {7'h00, b}, {7'h00, step_b});
    chk("dst_applied_flag", {7'h00, fl}, {7'h00, flag});
    @(negedge clk);
    chk("step after pulse", 8'h00, {7'h00, step_f | step_b});
  endtask
  task automatic stamp(input logic bat, input logic [7:0] base, input logic [39:0] exp);
    @(posedge clk);
    if (bat) to_battery <= 1'b1;
    else to_main <= 1'b1;
    @(posedge clk);
    to_battery <= 1'b0;
    to_main <= 1'b0;
    for (int i = 0; i < 5; i++) rd(base + 8'(i), exp[8*i +: 8]);
  endtask
  task automatic t_reset;
    logic [63:0] rv;
    rv = 64'h00000010_00000000;
    for (int i = 0; i < 8; i++) rd(8'h15 + 8'(i), rv[8*i +: 8]);
    rd(8'h07, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h40, 8'h00);
  endtask
  task automatic t_stamps;
    @(posedge clk);
    sec <= 8'h45;
    min <= 8'h30;
    at(8'h93, 8'h28, 8'h02, 3'h1);
    stamp(1'b1, 8'h30, 40'h02_28_93_30_45);
    @(posedge clk);
    sec <= 8'h12;
    stamp(1'b1, 8'h30, 40'h02_28_93_30_45);
    stamp(1'b0, 8'h35, 40'h02_28_93_30_12);
    rd(8'h38, 8'h28);
    rd(8'h3C, 8'h00);
    @(posedge clk);
    sec <= 8'h59;
    stamp(1'b0, 8'h35, 40'h02_28_93_30_59);
    wr(8'h09, 8'h01);
    for (int i = 0; i < 10; i++) rd(8'h30 + 8'(i), 8'h00);
    stamp(1'b1, 8'h30, 40'h02_28_93_30_59);
  endtask
  task automatic t_dst;
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h14);
    wr(8'h18, 8'h02);
    wr(8'h15, 8'h83);
    wr(8'h1A, 8'h78);
    wr(8'h1B, 8'h05);
    wr(8'h1C, 8'h03);
    rd(8'h1A, 8'h78);
    @(posedge clk);
    sec <= 8'h00;
    min <= 8'h00;
    at(8'h81, 8'h14, 8'h03, 3'h0);
    fire(1'b0, 1'b0, 1'b0);
    at(8'h82, 8'h14, 8'h03, 3'h0);
    fire(1'b1, 1'b0, 1'b1);
    rd(8'h07, 8'h01);
    fire(1'b0, 1'b0, 1'b1);
    // last sunday of october, date field ignored in week mode
    at(8'h83, 8'h27, 8'h10, 3'h0);
    fire(1'b0, 1'b1, 1'b0);
    at(8'h82, 8'h14, 8'h03, 3'h0);
    fire(1'b1, 1'b0, 1'b1);
    wr(8'h15, 8'h03);
    rd(8'h07, 8'h00);
    rd(8'h15, 8'h03);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_stamps();
    t_dst();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
